// >>> hw/crb_regs.sv
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - writing one then zero to reset bit pulses a device reset that keeps the held read data
// - writing one then zero to search bit starts a new frequency search
// - reference clock input is enabled while its power-down bit is zero
// - lock source bit picks reference clock or incoming data for lock check
// - two-bit band field selects one of four reference frequency bands
// - ratio codes up to ten give data-to-reference ratio two to the (code minus one)
// - edge field picks both, rising only or falling only transitions
// - transfer bandwidth equals default times field over four, default four
// - low two bits of slew register set delay loop bandwidth
// - signed phase offset in 1/32 UI applies only above 5.65 Gbps
// - termination common mode floats when top input bit set
// - input bit four picks adaptive or manual equalization
// - low four input bits set manual equalizer gain
// - output bit four turns recovered data output off
// - output bit two turns the double rate clock off
// - output bit one inverts output data polarity
// - in static mode one then zero on clear bit clears sticky loss flag
// - live loss bit reads zero locked, one during frequency acquisition
// - mode code 000 locks to data, 010 to reference, others reserved
module crb_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic acq_active,
  input wire logic rate_above_phase_min,
  input wire logic rec_data_in,
  output logic rec_data_out,
  output logic soft_reset_pulse,
  output logic freq_search_pulse,
  output crb_pkg::crb_loop_cfg_t loop_cfg,
  output crb_pkg::crb_fe_cfg_t fe_cfg
);

  // ****************************************************************
  // storage and write decode
  // ****************************************************************
  logic [7:0] mode_q;
  logic [7:0] reset_lock_q;
  logic [7:0] ref_pdn_q;
  logic [7:0] ref_setup_q;
  logic [7:0] loop_edge_q;
  logic [7:0] dll_slew_q;
  logic [7:0] phase_q;
  logic [7:0] input_q;
  logic [7:0] output_q;
  logic sticky_loss_q;
  logic soft_reset_q;
  logic freq_search_q;
  logic rec_data_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic clr_all;
  logic wr_mode;
  logic wr_reset_lock;
  logic loss_clear_fall;
  logic soft_reset_fall;
  logic freq_search_fall;

  // a software reset takes one cycle to return every register but the read data to default
  assign clr_all = !rst_n || soft_reset_q;
  assign wr_mode = wr_en && (addr == crb_pkg::ADDR_MODE);
  assign wr_reset_lock = wr_en && (addr == crb_pkg::ADDR_RESET_LOCK);

  // one-then-zero detection: a stored one overwritten by a zero
  assign soft_reset_fall = wr_reset_lock &&
    reset_lock_q[crb_pkg::BIT_SOFT_RESET] &&
    !wr_data[crb_pkg::BIT_SOFT_RESET];
  assign freq_search_fall = wr_reset_lock &&
    reset_lock_q[crb_pkg::BIT_FREQ_SEARCH] &&
    !wr_data[crb_pkg::BIT_FREQ_SEARCH];
  assign loss_clear_fall = wr_mode &&
    mode_q[crb_pkg::BIT_LOSS_CLEAR] &&
    !wr_data[crb_pkg::BIT_LOSS_CLEAR];

  // ****************************************************************
  // control registers
  // ****************************************************************

  // whole bytes are kept so reserved bits read back as written
  always_ff @(posedge clk) begin
    if (clr_all) begin
      mode_q <= crb_pkg::RST_MODE;
      reset_lock_q <= crb_pkg::RST_RESET_LOCK;
      ref_pdn_q <= crb_pkg::RST_REF_PDN;
      ref_setup_q <= crb_pkg::RST_REF_SETUP;
      loop_edge_q <= crb_pkg::RST_LOOP_EDGE;
      dll_slew_q <= crb_pkg::RST_DLL_SLEW;
      phase_q <= crb_pkg::RST_PHASE;
      input_q <= crb_pkg::RST_INPUT;
      output_q <= crb_pkg::RST_OUTPUT;
    end else if (wr_en) begin
      case (addr)
        crb_pkg::ADDR_MODE: mode_q <= wr_data;
        crb_pkg::ADDR_RESET_LOCK: reset_lock_q <= wr_data;
        crb_pkg::ADDR_REF_PDN: ref_pdn_q <= wr_data;
        crb_pkg::ADDR_REF_SETUP: ref_setup_q <= wr_data;
        crb_pkg::ADDR_LOOP_EDGE: loop_edge_q <= wr_data;
        crb_pkg::ADDR_DLL_SLEW: dll_slew_q <= wr_data;
        crb_pkg::ADDR_PHASE: phase_q <= wr_data;
        crb_pkg::ADDR_INPUT: input_q <= wr_data;
        crb_pkg::ADDR_OUTPUT: output_q <= wr_data;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // action pulses
  // ****************************************************************

  // soft reset pulse is reset only by the pin reset, not by the soft reset it drives
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= soft_reset_fall;
    end
  end

  // frequency search start pulse
  always_ff @(posedge clk) begin
    if (clr_all) begin
      freq_search_q <= 1'b0;
    end else begin
      freq_search_q <= freq_search_fall;
    end
  end

  assign soft_reset_pulse = soft_reset_q;
  assign freq_search_pulse = freq_search_q;

  // ****************************************************************
  // lock loss status
  // ****************************************************************

  // sticky flag: a new acquisition in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (clr_all) begin
      sticky_loss_q <= 1'b0;
    end else if (acq_active) begin
      sticky_loss_q <= 1'b1;
    end else if (loss_clear_fall &&
                 reset_lock_q[crb_pkg::BIT_STATIC_LOSS]) begin
      sticky_loss_q <= 1'b0;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************

  // unmapped addresses read as zero
  always_comb begin
    rd_data_d = 8'h00;
    case (addr)
      crb_pkg::ADDR_STATUS: begin
        rd_data_d[crb_pkg::BIT_LIVE_LOSS] = acq_active;
        rd_data_d[crb_pkg::BIT_STICKY_LOSS] = sticky_loss_q;
      end
      crb_pkg::ADDR_MODE: rd_data_d = mode_q;
      crb_pkg::ADDR_RESET_LOCK: rd_data_d = reset_lock_q;
      crb_pkg::ADDR_REF_PDN: rd_data_d = ref_pdn_q;
      crb_pkg::ADDR_REF_SETUP: rd_data_d = ref_setup_q;
      crb_pkg::ADDR_LOOP_EDGE: rd_data_d = loop_edge_q;
      crb_pkg::ADDR_DLL_SLEW: rd_data_d = dll_slew_q;
      crb_pkg::ADDR_PHASE: rd_data_d = phase_q;
      crb_pkg::ADDR_INPUT: rd_data_d = input_q;
      crb_pkg::ADDR_OUTPUT: rd_data_d = output_q;
      default: rd_data_d = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_q <= 8'h00;
    end else if (rd_en) begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;

  // ****************************************************************
  // loop settings
  // ****************************************************************

  // field decode toward the recovery loops
  always_comb begin
    loop_cfg.bypass = reset_lock_q[crb_pkg::BIT_BYPASS];
    loop_cfg.lock_to_data =
      (mode_q[6:4] == crb_pkg::MODE_LOCK_DATA);
    loop_cfg.lock_to_ref =
      (mode_q[6:4] == crb_pkg::MODE_LOCK_REF);
    loop_cfg.loss_vs_data = ref_setup_q[crb_pkg::BIT_LOSS_SRC];
    loop_cfg.ref_band = ref_setup_q[5:4];
    loop_cfg.ratio_code = ref_setup_q[3:0];
    // twice the ratio, so that code zero (one half) stays whole
    if (ref_setup_q[3:0] <= crb_pkg::RATIO_CODE_MAX) begin
      loop_cfg.ratio_x2 = 11'h001 << ref_setup_q[3:0];
    end else begin
      loop_cfg.ratio_x2 = 11'h000;
    end
    loop_cfg.edge_rise_en =
      (loop_edge_q[4:3] != crb_pkg::EDGE_FALL_ONLY);
    loop_cfg.edge_fall_en =
      (loop_edge_q[4:3] != crb_pkg::EDGE_RISE_ONLY);
    loop_cfg.bw_scale = loop_edge_q[2:0];
    loop_cfg.dll_slew = dll_slew_q[1:0];
    // offset forced to zero below the rate threshold
    loop_cfg.phase_offset =
      rate_above_phase_min ? phase_q[3:0] : 4'h0;
  end

  // ****************************************************************
  // front end and output settings
  // ****************************************************************

  always_comb begin
    fe_cfg.ref_clk_en = !ref_pdn_q[crb_pkg::BIT_REF_PDN];
    fe_cfg.term_float = input_q[crb_pkg::BIT_TERM_FLOAT];
    fe_cfg.input_sel = input_q[6:5];
    fe_cfg.auto_eq = input_q[crb_pkg::BIT_AUTO_EQ];
    // manual gain drives the equalizer only without adaptation
    fe_cfg.eq_gain =
      input_q[crb_pkg::BIT_AUTO_EQ] ? 4'h0 : input_q[3:0];
    fe_cfg.data_out_en = !output_q[crb_pkg::BIT_DATA_OFF];
    fe_cfg.ddr_clk_en = !output_q[crb_pkg::BIT_DDR_OFF];
    fe_cfg.invert = output_q[crb_pkg::BIT_POLARITY];
  end

  // retimed output data: disable and squelch hold it low
  always_ff @(posedge clk) begin
    if (clr_all) begin
      rec_data_q <= 1'b0;
    end else if (output_q[crb_pkg::BIT_DATA_OFF] ||
                 output_q[crb_pkg::BIT_SQUELCH]) begin
      rec_data_q <= 1'b0;
    end else begin
      rec_data_q <= rec_data_in ^ output_q[crb_pkg::BIT_POLARITY];
    end
  end

  assign rec_data_out = rec_data_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_soft_reset_seq: assert property (
    (wr_reset_lock && reset_lock_q[7] && !wr_data[7])
    |=> soft_reset_pulse ##1 (reset_lock_q == crb_pkg::RST_RESET_LOCK &&
      output_q == crb_pkg::RST_OUTPUT && !sticky_loss_q)
  ) else $error("soft reset sequence did not reset registers");

  chk_search_pulse: assert property (
    freq_search_pulse |-> $past(wr_reset_lock) && !$past(wr_data[6])
  ) else $error("frequency search pulse without one-then-zero");

  chk_ref_enable: assert property (
    fe_cfg.ref_clk_en == !ref_pdn_q[2]
  ) else $error("reference clock enable wrong");

  chk_loss_source: assert property (
    (wr_en && addr == crb_pkg::ADDR_REF_SETUP && !soft_reset_q)
    |=> loop_cfg.loss_vs_data == $past(wr_data[6])
  ) else $error("lock check source not taken from write");

  chk_ratio_value: assert property (
    (ref_setup_q[3:0] == 4'h1) |-> loop_cfg.ratio_x2 == 11'h002
  ) else $error("ratio code one must give ratio one");

  chk_edge_rising: assert property (
    (loop_edge_q[4:3] == 2'h1) |-> loop_cfg.edge_rise_en
    && !loop_cfg.edge_fall_en
  ) else $error("rising edge select wrong");

  chk_phase_gate: assert property (
    !rate_above_phase_min |-> loop_cfg.phase_offset == 4'h0
  ) else $error("phase offset applied below rate threshold");

  chk_manual_gain: assert property (
    !input_q[4] |-> fe_cfg.eq_gain == input_q[3:0]
  ) else $error("manual gain not applied");

  chk_data_off: assert property (
    output_q[4] |=> !rec_data_out
  ) else $error("data output not held off");

  chk_polarity: assert property (
    (!soft_reset_q && output_q[5:4] == 2'h0 && $stable(output_q))
    |=> rec_data_out == ($past(rec_data_in) ^ $past(output_q[1]))
  ) else $error("output polarity wrong");

  chk_sticky_clear: assert property (
    (loss_clear_fall && reset_lock_q[4] && !acq_active && !soft_reset_q)
    |=> !sticky_loss_q
  ) else $error("sticky loss flag not cleared");

  chk_sticky_set: assert property (
    (acq_active && !soft_reset_q) |=> sticky_loss_q
  ) else $error("acquisition did not set sticky flag");

  chk_live_status: assert property (
    (rd_en && addr == crb_pkg::ADDR_STATUS)
    |=> rd_data[4] == $past(acq_active)
  ) else $error("live loss status wrong");

  chk_mode_ref: assert property (
    (mode_q[6:4] == 3'h2) |-> loop_cfg.lock_to_ref && !loop_cfg.lock_to_data
  ) else $error("lock to reference decode wrong");

  cov_soft_reset: cover property (soft_reset_pulse);
  cov_search: cover property (freq_search_pulse);
  chk_band_select: assert property (
    (wr_en && addr == crb_pkg::ADDR_REF_SETUP && !soft_reset_q)
    |=> loop_cfg.ref_band == $past(wr_data[5:4])
  ) else $error("reference band not taken from write");

  chk_ddr_clock: assert property (
    (wr_en && addr == crb_pkg::ADDR_OUTPUT && !soft_reset_q)
    |=> fe_cfg.ddr_clk_en == !$past(wr_data[2])
  ) else $error("double rate clock enable wrong");

  chk_term_float: assert property (
    (wr_en && addr == crb_pkg::ADDR_INPUT && !soft_reset_q)
    |=> fe_cfg.term_float == $past(wr_data[7])
  ) else $error("termination float not taken from write");

  cov_sticky_clear: cover property (sticky_loss_q ##1 !sticky_loss_q);
  cov_invert: cover property (fe_cfg.invert && rec_data_out);
  cov_lock_ref: cover property (loop_cfg.lock_to_ref);

endmodule

`default_nettype wire

// >>> inc/crb_pkg.sv
package crb_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS = 8'h06;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_RESET_LOCK = 8'h09;
  localparam logic [7:0] ADDR_REF_PDN = 8'h0a;
  localparam logic [7:0] ADDR_REF_SETUP = 8'h0f;
  localparam logic [7:0] ADDR_LOOP_EDGE = 8'h10;
  localparam logic [7:0] ADDR_DLL_SLEW = 8'h13;
  localparam logic [7:0] ADDR_PHASE = 8'h14;
  localparam logic [7:0] ADDR_INPUT = 8'h16;
  localparam logic [7:0] ADDR_OUTPUT = 8'h1e;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_RESET_LOCK = 8'h08;
  localparam logic [7:0] RST_REF_PDN = 8'h05;
  localparam logic [7:0] RST_REF_SETUP = 8'h00;
  localparam logic [7:0] RST_LOOP_EDGE = 8'h04;
  localparam logic [7:0] RST_DLL_SLEW = 8'h00;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_INPUT = 8'h20;
  localparam logic [7:0] RST_OUTPUT = 8'h08;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_FREQ_SEARCH = 6;
  localparam int BIT_BYPASS = 5;
  localparam int BIT_STATIC_LOSS = 4;
  localparam int BIT_LOSS_CLEAR = 2;
  localparam int BIT_REF_PDN = 2;
  localparam int BIT_LOSS_SRC = 6;
  localparam int BIT_LIVE_LOSS = 4;
  localparam int BIT_STICKY_LOSS = 2;
  localparam int BIT_TERM_FLOAT = 7;
  localparam int BIT_AUTO_EQ = 4;
  localparam int BIT_SQUELCH = 5;
  localparam int BIT_DATA_OFF = 4;
  localparam int BIT_DDR_OFF = 2;
  localparam int BIT_POLARITY = 1;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [2:0] MODE_LOCK_DATA = 3'h0;
  localparam logic [2:0] MODE_LOCK_REF = 3'h2;
  localparam logic [1:0] EDGE_RISE_ONLY = 2'h1;
  localparam logic [1:0] EDGE_FALL_ONLY = 2'h2;
  localparam logic [3:0] RATIO_CODE_MAX = 4'ha;

  // settings handed to the recovery loops
  typedef struct packed {
    logic       bypass;
    logic       lock_to_data;
    logic       lock_to_ref;
    logic       loss_vs_data;
    logic [1:0] ref_band;
    logic [3:0] ratio_code;
    logic [10:0] ratio_x2;
    logic       edge_rise_en;
    logic       edge_fall_en;
    logic [2:0] bw_scale;
    logic [1:0] dll_slew;
    logic [3:0] phase_offset;
  } crb_loop_cfg_t;

  // settings handed to the analog front end and output stage
  typedef struct packed {
    logic       ref_clk_en;
    logic       term_float;
    logic [1:0] input_sel;
    logic       auto_eq;
    logic [3:0] eq_gain;
    logic       data_out_en;
    logic       ddr_clk_en;
    logic       invert;
  } crb_fe_cfg_t;

endpackage

// >>> sim/crb_loop_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// recovery loop stand-in
// ****************************************************************
module crb_loop_model #(
  parameter int ACQ_CYCLES = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset_pulse,
  input wire logic freq_search_pulse,
  output logic acq_active,
  output var logic rate_above_phase_min,
  output var logic rec_data_in
);
  int cnt_q;

  // each search request runs a fixed acquisition, a reset aborts it
  always_ff @(posedge clk) begin
    if (!rst_n || soft_reset_pulse) begin
      cnt_q <= 0;
    end else if (freq_search_pulse) begin
      cnt_q <= ACQ_CYCLES;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end

  // live acquisition flag seen by the register bank
  assign acq_active = (cnt_q != 0);

  // data bit and rate flag change every cycle just after the edge
  initial begin
    rate_above_phase_min = 1'b0;
    rec_data_in = 1'b0;
    forever begin
      @(posedge clk);
      #1;
      rec_data_in = 1'($urandom());
      rate_above_phase_min = 1'($urandom());
    end
  end
endmodule

`default_nettype wire

// >>> sim/crb_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
  end \
end

module crb_regs_tb;
  logic clk = 1'b0;
  logic rst_n, wr_en, rd_en, rec_data_out, rd_seen;
  logic soft_reset_pulse, freq_search_pulse;
  logic acq_active, rate_above_phase_min, rec_data_in;
  logic [7:0] addr, wr_data, rd_data, rd_exp;
  logic [1:0] pl_exp;
  crb_pkg::crb_loop_cfg_t loop_cfg;
  crb_pkg::crb_fe_cfg_t fe_cfg;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [7:0] rd_q[$];
  logic [1:0] pulse_q[$];
  // ****************************************************************
  // register table: offset, free bits, fixed bits, reset value
  // ****************************************************************
  logic [7:0] tab_a[9] = '{crb_pkg::ADDR_MODE, crb_pkg::ADDR_RESET_LOCK,
    crb_pkg::ADDR_REF_PDN, crb_pkg::ADDR_REF_SETUP, crb_pkg::ADDR_LOOP_EDGE,
    crb_pkg::ADDR_DLL_SLEW, crb_pkg::ADDR_PHASE, crb_pkg::ADDR_INPUT,
    crb_pkg::ADDR_OUTPUT};
  logic [7:0] tab_m[9] = '{8'h77, 8'h30, 8'h04, 8'h7f, 8'h1f, 8'h03, 8'h0f,
    8'h9f, 8'h36};
  logic [7:0] tab_f[9] = '{8'h00, 8'h08, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h20, 8'h08};
  logic [7:0] tab_r[9] = '{8'h00, 8'h08, 8'h05, 8'h00, 8'h04, 8'h00, 8'h00,
    8'h20, 8'h08};

  // free-running bench clock
  always #12.5 clk = ~clk;

  crb_regs dut (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
    .acq_active(acq_active), .rate_above_phase_min(rate_above_phase_min),
    .rec_data_in(rec_data_in), .rec_data_out(rec_data_out),
    .soft_reset_pulse(soft_reset_pulse),
    .freq_search_pulse(freq_search_pulse), .loop_cfg(loop_cfg),
    .fe_cfg(fe_cfg));

  crb_loop_model u_loop (.clk(clk), .rst_n(rst_n),
    .soft_reset_pulse(soft_reset_pulse),
    .freq_search_pulse(freq_search_pulse), .acq_active(acq_active),
    .rate_above_phase_min(rate_above_phase_min), .rec_data_in(rec_data_in));

  // monitor: read data one cycle after the strobe, pulses when they appear
  always @(posedge clk) begin
    if (rd_seen === 1'b1) begin
      rd_exp = (rd_q.size() != 0) ? rd_q.pop_front() : 8'hxx;
      `CHK(rd_data, rd_exp)
    end
    if (soft_reset_pulse === 1'b1 || freq_search_pulse === 1'b1) begin
      pl_exp = (pulse_q.size() != 0) ? pulse_q.pop_front() : 2'b00;
      `CHK({soft_reset_pulse, freq_search_pulse}, pl_exp)
    end
    rd_seen <= rd_en;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // strobes stay up so that operations run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rd_en = 1'b0;
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(posedge clk);
    #2;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wr_en = 1'b0;
    rd_en = 1'b1;
    addr = a;
    rd_q.push_back(e);
    @(posedge clk);
    #2;
  endtask

  task automatic idle();
    wr_en = 1'b0;
    rd_en = 1'b0;
    @(posedge clk);
    #2;
  endtask

  task automatic out_chk(input logic [7:0] v);
    logic d;
    idle();
    repeat (3) begin
      d = rec_data_in;
      @(posedge clk);
      #2;
      `CHK(rec_data_out, (d ^ v[1]) & ~v[4] & ~v[5])
    end
  endtask

  // decoded settings against the value just written
  task automatic chk_cfg(input logic [7:0] a, input logic [7:0] v);
    case (a)
      crb_pkg::ADDR_MODE: begin
        `CHK(loop_cfg.lock_to_data, v[6:4] == 3'h0)
        `CHK(loop_cfg.lock_to_ref, v[6:4] == 3'h2)
      end
      crb_pkg::ADDR_REF_PDN: `CHK(fe_cfg.ref_clk_en, ~v[2])
      crb_pkg::ADDR_REF_SETUP: begin
        `CHK(loop_cfg.loss_vs_data, v[6])
        `CHK(loop_cfg.ref_band, v[5:4])
        `CHK(loop_cfg.ratio_x2, (v[3:0] <= 4'ha) ? 11'(1) << v[3:0] :
          11'h0)
      end
      crb_pkg::ADDR_LOOP_EDGE: begin
        `CHK(loop_cfg.edge_rise_en, v[4:3] != 2'h2)
        `CHK(loop_cfg.edge_fall_en, v[4:3] != 2'h1)
        `CHK(loop_cfg.bw_scale, v[2:0])
      end
      crb_pkg::ADDR_DLL_SLEW: `CHK(loop_cfg.dll_slew, v[1:0])
      crb_pkg::ADDR_PHASE: begin
        `CHK(loop_cfg.phase_offset, rate_above_phase_min ? v[3:0] :
          4'h0)
      end
      crb_pkg::ADDR_INPUT: begin
        `CHK(fe_cfg.term_float, v[7])
        `CHK(fe_cfg.auto_eq, v[4])
        `CHK(fe_cfg.eq_gain, v[4] ? 4'h0 : v[3:0])
      end
      crb_pkg::ADDR_OUTPUT: begin
        `CHK(fe_cfg.data_out_en, ~v[4])
        `CHK(fe_cfg.ddr_clk_en, ~v[2])
        `CHK(fe_cfg.invert, v[1])
        out_chk(v);
      end
      default: ;
    endcase
  endtask

  task automatic wc(input logic [7:0] a, input logic [7:0] v);
    wr(a, v);
    chk_cfg(a, v);
  endtask

  task automatic wait_acq(input logic lvl);
    int n;
    idle();
    for (n = 0; n < 20 && acq_active !== lvl; n++) begin
      @(posedge clk);
      #2;
    end
    if (acq_active !== lvl) begin
      n_mismatch++;
      test_done();
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int i;
    logic [7:0] v;
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    rd_seen = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    void'($urandom(31));
    repeat (4) @(posedge clk);
    #2;
    rst_n = 1'b1;
    // defaults, unmapped place and read-only status
    for (i = 0; i < 9; i++) begin
      chk_cfg(tab_a[i], tab_r[i]);
      rd(tab_a[i], tab_r[i]);
    end
    wr(8'h07, 8'hff);
    wr(crb_pkg::ADDR_STATUS, 8'hff);
    rd(8'h07, 8'h00);
    rd(crb_pkg::ADDR_STATUS, 8'h00);
    // random settings with reserved bits at their fixed values
    repeat (12) begin
      for (i = 0; i < 9; i++) begin
        v = (8'($urandom()) & tab_m[i]) | tab_f[i];
        wc(tab_a[i], v);
        rd(tab_a[i], v);
      end
    end
    // every ratio, edge and mode code
    for (i = 0; i < 16; i++) begin
      wc(crb_pkg::ADDR_REF_SETUP, 8'(i));
      wc(crb_pkg::ADDR_LOOP_EDGE, 8'(i << 1) & 8'h1f);
      wc(crb_pkg::ADDR_MODE, 8'(i << 4) & 8'h70);
    end
    // search request, live and sticky loss flags
    wr(crb_pkg::ADDR_RESET_LOCK, 8'h48);
    pulse_q.push_back(2'b01);
    wr(crb_pkg::ADDR_RESET_LOCK, 8'h08);
    `CHK(freq_search_pulse, 1'b1)
    wait_acq(1'b1);
    // sticky flag is set one cycle after the live flag rises
    idle();
    rd(crb_pkg::ADDR_STATUS, 8'h14);
    wait_acq(1'b0);
    rd(crb_pkg::ADDR_STATUS, 8'h04);
    wr(crb_pkg::ADDR_MODE, 8'h04);
    wr(crb_pkg::ADDR_MODE, 8'h00);
    idle();
    rd(crb_pkg::ADDR_STATUS, 8'h04);
    wr(crb_pkg::ADDR_RESET_LOCK, 8'h18);
    wr(crb_pkg::ADDR_MODE, 8'h04);
    wr(crb_pkg::ADDR_MODE, 8'h00);
    idle();
    rd(crb_pkg::ADDR_STATUS, 8'h00);
    // software reset brings the output and reset-lock registers back
    wr(crb_pkg::ADDR_OUTPUT, 8'h3e);
    wr(crb_pkg::ADDR_RESET_LOCK, 8'h88);
    pulse_q.push_back(2'b10);
    wr(crb_pkg::ADDR_RESET_LOCK, 8'h08);
    `CHK(soft_reset_pulse, 1'b1)
    idle();
    rd(crb_pkg::ADDR_OUTPUT, crb_pkg::RST_OUTPUT);
    rd(crb_pkg::ADDR_RESET_LOCK, crb_pkg::RST_RESET_LOCK);
    idle();
    idle();
    `CHK(pulse_q.size(), 0)
    `CHK(rd_q.size(), 0)
    test_done();
  end
endmodule

`default_nettype wire
